// [dpsd_defs.vh]
// Purpose: shared constants of the diagnostic telegram assembler
// Assumes: included by bare name from every design file
// Notes: definitions only
`ifndef DPSD_DEFS_VH
`define DPSD_DEFS_VH

// process image block layout (byte offsets inside the 6-byte block)
`define DPSD_OFF_STATUS 3'h0
`define DPSD_OFF_PAY_FIRST 3'h1
`define DPSD_BLK_LEN 3'h6
`define DPSD_PAY_BYTES 5

// diagnostic status byte fields and special values
`define DPSD_ST_VALID 0
`define DPSD_ST_DELETE 1
`define DPSD_STAT_IGNORE 8'h03
`define DPSD_STAT_RESET 8'h00

// telegram byte positions
`define DPSD_TEL_ST1 4'h0
`define DPSD_TEL_ST2 4'h1
`define DPSD_TEL_ST3 4'h2
`define DPSD_TEL_MADDR 4'h3
`define DPSD_TEL_ID_A 4'h4
`define DPSD_TEL_ID_B 4'h5
`define DPSD_TEL_HDR 4'h6
`define DPSD_TEL_MSG 4'h7
`define DPSD_TEL_USR0 4'hb
`define DPSD_TEL_USR1 4'hc
`define DPSD_TEL_USR2 4'hd
`define DPSD_TEL_USR3 4'he
`define DPSD_TEL_USR4 4'hf
`define DPSD_TEL_FIRST 4'h0
`define DPSD_TEL_LAST 4'hf

// device specific header and message codes
`define DPSD_DEV_LEN 6'h0a
`define DPSD_DEV_CODE 2'h0
`define DPSD_MSG_NONE 8'h00
`define DPSD_MSG_ERR_LO 8'h12
`define DPSD_MSG_ERR_HI 8'h17
`define DPSD_MSG_USER 8'h40
`define DPSD_BYTE_ZERO 8'h00

`endif

// [dpsd_tel_byte.v]
// Purpose: selects one byte of the 16-byte diagnostic telegram
// Assumes: purely combinational, index from the sender in the main module
// Notes: fixed bits are forced here so no caller can disturb them
`timescale 1ns/1ps
`default_nettype none
`include "dpsd_defs.vh"

module dpsd_tel_byte (
    // selection
    input wire [3:0] idx,
    // station status sources
    input wire [5:0] st1_flags,
    input wire [4:0] st2_flags,
    input wire ovf_flag,
    input wire [7:0] master_addr,
    input wire [15:0] ident_num,
    // device specific content
    input wire [7:0] msg_code,
    input wire [39:0] user_bytes,
    // result
    output reg [7:0] tel_byte
);
    // st1_flags: {wrong_param, unsupported, ext_diag, cfg_mismatch, not_ready}, bit5 unused
    always @* begin
        tel_byte = `DPSD_BYTE_ZERO;
        case (idx)
            `DPSD_TEL_ST1: tel_byte = {1'b0, st1_flags[4], 1'b0, st1_flags[3:0], 1'b0};
            `DPSD_TEL_ST2: tel_byte = {2'b00, st2_flags[4:2], 1'b1, st2_flags[1:0]};
            `DPSD_TEL_ST3: tel_byte = {ovf_flag, 7'h00};
            `DPSD_TEL_MADDR: tel_byte = master_addr;
            `DPSD_TEL_ID_A: tel_byte = ident_num[15:8];
            `DPSD_TEL_ID_B: tel_byte = ident_num[7:0];
            `DPSD_TEL_HDR: tel_byte = {`DPSD_DEV_CODE, `DPSD_DEV_LEN};
            `DPSD_TEL_MSG: tel_byte = msg_code;
            `DPSD_TEL_USR0: tel_byte = user_bytes[7:0];
            `DPSD_TEL_USR1: tel_byte = user_bytes[15:8];
            `DPSD_TEL_USR2: tel_byte = user_bytes[23:16];
            `DPSD_TEL_USR3: tel_byte = user_bytes[31:24];
            `DPSD_TEL_USR4: tel_byte = user_bytes[39:32];
            default: tel_byte = `DPSD_BYTE_ZERO;
        endcase
    end
endmodule // dpsd_tel_byte

`default_nettype wire

// [dpsd_assembler.v]
// Purpose: builds and streams the slave diagnostic telegram, owns the 6-byte image block
// Assumes: all inputs come from logic on the same clock, no synchronisers needed
// Notes: telegram bytes are read live while streaming except the user bytes and the message code
`timescale 1ns/1ps
`default_nettype none
`include "dpsd_defs.vh"

// Function
// - answer master requests, send unsolicited on errors
// - telegram bytes 0-5 standard, 6-15 device specific
// - station status 1 with bits 0,5,7 zero
// - station status 2 bit 2 one, bit 7 zero
// - station status 3 bit 7 is overflow
// - byte 3 master address, bytes 4-5 ident
// - byte 6 length ten, code zero
// - byte 7 carries the message code
// - bytes 11-15 forward processor user bytes
// - image block holds status then user bytes
// - block base set by configuration input
// - status bit rising zero to one starts diagnostic
// - status value 03h is ignored entirely
// - bit0 valid/start, bit1 delete, rest reserved
module dpsd_assembler #(
    parameter AW = 11
) (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // process image access from the local processor
    input wire [AW-1:0] cfg_diag_base,
    input wire pi_wr,
    input wire pi_rd,
    input wire [AW-1:0] pi_addr,
    input wire [7:0] pi_wdata,
    output reg [7:0] pi_rdata_r,
    output reg pi_hit_r,
    // station state from the slave protocol logic
    input wire st_not_ready,
    input wire st_cfg_mismatch,
    input wire st_unsupported,
    input wire st_wrong_param,
    input wire st_need_param,
    input wire st_static_diag,
    input wire st_resp_mon,
    input wire st_freeze_rx,
    input wire st_sync_rx,
    input wire st_overflow,
    input wire [7:0] master_addr,
    input wire [15:0] ident_num,
    // internal error report
    input wire err_active,
    input wire [7:0] err_code,
    // master diagnostic request
    input wire diag_req,
    // telegram byte stream toward the framing layer
    output reg tx_valid_r,
    input wire tx_ready,
    output reg [7:0] tx_byte_r,
    output reg [3:0] tx_index_r,
    output reg tx_last_r,
    output reg tx_spont_r,
    // visible state
    output reg user_valid_r,
    output reg [7:0] msg_code_r
);
    localparam ST_IDLE = 1'b0;
    localparam ST_SEND = 1'b1;

    reg state_r;
    reg state_nxt;
    reg [7:0] stat_r;
    reg [39:0] pay_r;
    reg [39:0] tel_user_r;
    reg req_pend_r;
    reg spont_pend_r;
    reg err_seen_r;
    reg [7:0] err_code_seen_r;
    reg cur_spont_r;
    reg [7:0] cur_msg_r;
    reg [3:0] idx_r;
    reg [3:0] idx_nxt;

    wire [AW-1:0] blk_off_full;
    wire [2:0] blk_off;
    wire blk_hit;
    wire stat_wr;
    wire stat_ok;
    wire trig_evt;
    wire del_evt;
    wire err_code_ok;
    wire err_evt;
    wire start_send;
    wire byte_taken;
    wire send_done;
    wire [7:0] msg_live;
    wire [7:0] tel_byte;
    wire [2:0] pay_sel;
    wire blk_rd;
    wire pay_wr;
    wire [7:0] tel_msg;

    // block decode, base comes from the processor configuration
    // a base change only moves later accesses, nothing is relocated
    assign blk_off_full = pi_addr - cfg_diag_base;
    assign blk_off = blk_off_full[2:0];
    assign blk_hit = (pi_addr >= cfg_diag_base) &&
                     (blk_off_full < {{(AW-3){1'b0}}, `DPSD_BLK_LEN});
    assign pay_sel = blk_off - `DPSD_OFF_PAY_FIRST;
    assign blk_rd = pi_rd && blk_hit;
    assign pay_wr = pi_wr && blk_hit && (blk_off != `DPSD_OFF_STATUS);

    // status byte handling
    // 03h is dropped whole, so the stored edge reference stays put
    assign stat_wr = pi_wr && blk_hit && (blk_off == `DPSD_OFF_STATUS);
    assign stat_ok = stat_wr && (pi_wdata != `DPSD_STAT_IGNORE);
    assign trig_evt = stat_ok && pi_wdata[`DPSD_ST_VALID] && !stat_r[`DPSD_ST_VALID];
    assign del_evt = stat_ok && pi_wdata[`DPSD_ST_DELETE];

    // an error is only reported with a code from the defined range
    assign err_code_ok = (err_code >= `DPSD_MSG_ERR_LO) && (err_code <= `DPSD_MSG_ERR_HI);
    assign err_evt = err_active && err_code_ok &&
                     (!err_seen_r || (err_code != err_code_seen_r));

    // message code: a pending error outranks user data
    assign msg_live = (err_active && err_code_ok) ? err_code :
                      (user_valid_r ? `DPSD_MSG_USER : `DPSD_MSG_NONE);

    // one code per telegram, so byte 0 and byte 7 never disagree mid-stream
    assign tel_msg = start_send ? msg_live : cur_msg_r;

    assign byte_taken = tx_valid_r && tx_ready;
    assign send_done = byte_taken && (idx_r == `DPSD_TEL_LAST);
    assign start_send = (state_r == ST_IDLE) && (req_pend_r || spont_pend_r);

    // image block write: status byte and five user bytes
    always @(posedge clock) begin
        if (!rst_n) begin
            stat_r <= `DPSD_STAT_RESET;
        end else if (stat_ok) begin
            stat_r <= pi_wdata;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `DPSD_PAY_BYTES; gi = gi + 1) begin : g_pay
            always @(posedge clock) begin
                if (!rst_n) begin
                    pay_r[8*gi +: 8] <= `DPSD_BYTE_ZERO;
                end else if (pay_wr && (pay_sel == gi)) begin
                    pay_r[8*gi +: 8] <= pi_wdata;
                end
            end
        end
    endgenerate

    // image block read back
    always @(posedge clock) begin
        if (!rst_n) begin
            pi_rdata_r <= `DPSD_BYTE_ZERO;
            pi_hit_r <= 1'b0;
        end else begin
            pi_hit_r <= blk_rd;
            if (!blk_rd) begin
                pi_rdata_r <= `DPSD_BYTE_ZERO;
            end else if (blk_off == `DPSD_OFF_STATUS) begin
                pi_rdata_r <= stat_r;
            end else begin
                pi_rdata_r <= pay_r[8*pay_sel +: 8];
            end
        end
    end

    // user data validity and the forwarded copy of the user bytes
    // the copy is frozen at the trigger; later payload writes wait for the next one
    always @(posedge clock) begin
        if (!rst_n) begin
            user_valid_r <= 1'b0;
            tel_user_r <= 40'h00_0000_0000;
        end else if (trig_evt) begin
            user_valid_r <= 1'b1;
            tel_user_r <= pay_r;
        end else if (del_evt || (stat_ok && !pi_wdata[`DPSD_ST_VALID])) begin
            user_valid_r <= 1'b0;
        end
    end

    // error edge tracking
    // a new code while still active counts as a fresh error
    always @(posedge clock) begin
        if (!rst_n) begin
            err_seen_r <= 1'b0;
            err_code_seen_r <= `DPSD_MSG_NONE;
        end else begin
            err_seen_r <= err_active && err_code_ok;
            err_code_seen_r <= err_code;
        end
    end

    // pending send flags; a new event in the start cycle stays pending
    // events that arrive before the start merge into one telegram
    always @(posedge clock) begin
        if (!rst_n) begin
            req_pend_r <= 1'b0;
            spont_pend_r <= 1'b0;
        end else begin
            if (diag_req) begin
                req_pend_r <= 1'b1;
            end else if (start_send) begin
                req_pend_r <= 1'b0;
            end
            if (trig_evt || del_evt || err_evt) begin
                spont_pend_r <= 1'b1;
            end else if (start_send) begin
                spont_pend_r <= 1'b0;
            end
        end
    end

    // telegram byte selection
    dpsd_tel_byte u_tel_byte (
        .idx(idx_nxt),
        .st1_flags({1'b0, st_wrong_param, st_unsupported, (tel_msg != `DPSD_MSG_NONE),
                    st_cfg_mismatch, st_not_ready}),
        .st2_flags({st_sync_rx, st_freeze_rx, st_resp_mon, st_static_diag, st_need_param}),
        .ovf_flag(st_overflow),
        .master_addr(master_addr),
        .ident_num(ident_num),
        .msg_code(tel_msg),
        .user_bytes(tel_user_r),
        .tel_byte(tel_byte)
    );

    // sender state machine
    // the index parks at zero while idle so byte 0 is ready at the start
    always @* begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        case (state_r)
            ST_IDLE: begin
                idx_nxt = `DPSD_TEL_FIRST;
                if (start_send) begin
                    state_nxt = ST_SEND;
                end
            end
            ST_SEND: begin
                if (send_done) begin
                    state_nxt = ST_IDLE;
                    idx_nxt = `DPSD_TEL_FIRST;
                end else if (byte_taken) begin
                    idx_nxt = idx_r + 4'h1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                idx_nxt = `DPSD_TEL_FIRST;
            end
        endcase
    end

    // stream registers, held while the framer stalls
    always @(posedge clock) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            idx_r <= `DPSD_TEL_FIRST;
            tx_valid_r <= 1'b0;
            tx_byte_r <= `DPSD_BYTE_ZERO;
            tx_index_r <= `DPSD_TEL_FIRST;
            tx_last_r <= 1'b0;
            tx_spont_r <= 1'b0;
            cur_spont_r <= 1'b0;
            cur_msg_r <= `DPSD_MSG_NONE;
            msg_code_r <= `DPSD_MSG_NONE;
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            msg_code_r <= msg_live;
            if (start_send) begin
                // a master request wins the label when both are pending
                cur_spont_r <= !req_pend_r;
                cur_msg_r <= msg_live;
                tx_valid_r <= 1'b1;
                tx_byte_r <= tel_byte;
                tx_index_r <= idx_nxt;
                tx_last_r <= 1'b0;
                tx_spont_r <= !req_pend_r;
            end else if (send_done) begin
                tx_valid_r <= 1'b0;
                tx_last_r <= 1'b0;
                tx_spont_r <= 1'b0;
                tx_byte_r <= `DPSD_BYTE_ZERO;
                tx_index_r <= `DPSD_TEL_FIRST;
            end else if (byte_taken) begin
                tx_byte_r <= tel_byte;
                tx_index_r <= idx_nxt;
                tx_last_r <= (idx_nxt == `DPSD_TEL_LAST);
                tx_spont_r <= cur_spont_r;
            end
        end
    end
endmodule // dpsd_assembler

`default_nettype wire

// [dpsd_assembler_asserts.sv]
// Purpose: port checks for the diagnostic telegram assembler
// Assumes: one clock, synchronous active low reset
// Notes: bound to every assembler instance below
`timescale 1ns/1ps
`default_nettype none
module dpsd_assembler_chk #(
    parameter AW = 11
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // image bus
    input wire logic [AW-1:0] cfg_diag_base,
    input wire logic pi_wr,
    input wire logic pi_rd,
    input wire logic [AW-1:0] pi_addr,
    input wire logic [7:0] pi_wdata,
    input wire logic pi_hit_r,
    // stream and state
    input wire logic diag_req,
    input wire logic tx_valid_r,
    input wire logic tx_ready,
    input wire logic [7:0] tx_byte_r,
    input wire logic [3:0] tx_index_r,
    input wire logic tx_last_r,
    input wire logic tx_spont_r,
    input wire logic user_valid_r
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire in_blk = pi_addr >= cfg_diag_base && pi_addr < cfg_diag_base + 6;
    wire stat_wr = pi_wr && pi_addr == cfg_diag_base;

    a_st1_fixed: assert property (
        tx_valid_r && tx_index_r == 4'h0 |-> tx_byte_r[7] == 1'b0 && tx_byte_r[5] == 1'b0
            && tx_byte_r[0] == 1'b0) else $error("station byte 0 fixed bits wrong");
    a_st2_fixed: assert property (
        tx_valid_r && tx_index_r == 4'h1 |-> tx_byte_r[2] && !tx_byte_r[7])
        else $error("station byte 1 fixed bits wrong");
    a_st3_reserved: assert property (
        tx_valid_r && tx_index_r == 4'h2 |-> tx_byte_r[6:0] == 7'h00)
        else $error("station byte 2 reserved bits set");
    a_hdr_fixed: assert property (
        tx_valid_r && tx_index_r == 4'h6 |-> tx_byte_r == 8'h0a) else $error("header not 0a");
    a_gap_zero: assert property (
        tx_valid_r && tx_index_r inside {4'h8, 4'h9, 4'ha} |-> tx_byte_r == 8'h00)
        else $error("bytes 8 to 10 not zero");
    a_index_step: assert property (
        tx_valid_r && tx_ready && !tx_last_r |=> tx_valid_r
            && tx_index_r == $past(tx_index_r) + 4'h1) else $error("index did not step");
    a_byte_hold: assert property (
        tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_byte_r) && $stable(tx_index_r))
        else $error("byte changed while stalled");
    a_last_flag: assert property (
        tx_valid_r |-> tx_last_r == (tx_index_r == 4'hf)) else $error("last flag misplaced");
    a_req_answer: assert property (
        diag_req |-> ##[1:100] tx_valid_r && tx_index_r == 4'h0 && !tx_spont_r)
        else $error("request not answered");
    a_read_hit: assert property (
        pi_rd |=> pi_hit_r == $past(in_blk)) else $error("read hit wrong");
    a_ignore_three: assert property (
        stat_wr && pi_wdata == 8'h03 |=> user_valid_r == $past(user_valid_r))
        else $error("03h write acted on");
    a_trigger_valid: assert property (
        stat_wr && pi_wdata[0] && pi_wdata != 8'h03 |=> user_valid_r)
        else $error("trigger did not set valid");

    c_telegram: cover property (tx_valid_r && tx_ready && tx_last_r);
    c_spont: cover property (tx_valid_r && tx_spont_r);
    c_stall: cover property (tx_valid_r && !tx_ready);
endmodule // dpsd_assembler_chk

bind dpsd_assembler dpsd_assembler_chk #(.AW(AW)) i_dpsd_assembler_chk (
    .clock(clock), .rst_n(rst_n), .cfg_diag_base(cfg_diag_base), .pi_wr(pi_wr),
    .pi_rd(pi_rd), .pi_addr(pi_addr), .pi_wdata(pi_wdata), .pi_hit_r(pi_hit_r),
    .diag_req(diag_req), .tx_valid_r(tx_valid_r), .tx_ready(tx_ready),
    .tx_byte_r(tx_byte_r), .tx_index_r(tx_index_r), .tx_last_r(tx_last_r),
    .tx_spont_r(tx_spont_r), .user_valid_r(user_valid_r));
`default_nettype wire

// [dpsd_master_model.sv]
// Purpose: collecting master at the far end of the telegram stream
// Assumes: same clock as the assembler
// Notes: stall makes it accept only every other cycle
`timescale 1ns/1ps
`default_nettype none
module dpsd_master_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // telegram stream
    input wire logic tx_valid_r,
    input wire logic [7:0] tx_byte_r,
    input wire logic [3:0] tx_index_r,
    input wire logic tx_last_r,
    input wire logic tx_spont_r,
    output logic tx_ready,
    // test control
    input wire logic stall
);
    logic [7:0] tel [16];
    logic spont;
    int tel_cnt;
    always @(posedge clock) begin
        if (!rst_n) begin
            tx_ready <= 1'b0;
            tel_cnt <= 0;
        end else begin
            tx_ready <= !stall || !tx_ready;
            if (tx_valid_r && tx_ready) begin
                tel[tx_index_r] <= tx_byte_r;
                spont <= tx_spont_r;
                if (tx_last_r) tel_cnt <= tel_cnt + 1;
            end
        end
    end
endmodule // dpsd_master_model
`default_nettype wire

// [dp_slave_diagnostic_assembler_tb.sv]
// Purpose: self-checking bench for the diagnostic telegram assembler
// Assumes: master model collects each telegram
// Notes: error release is assumed to send nothing
`timescale 1ns/1ps
`default_nettype none
module dp_slave_diagnostic_assembler_tb;
    logic clock, rst_n, pi_wr, pi_rd, diag_req, err_active, tx_ready, stall;
    logic [10:0] base, pi_addr;
    logic [7:0] pi_wdata, err_code, ma, pi_rdata_r, tx_byte_r, msg_code_r;
    logic [9:0] st;
    logic [15:0] idn;
    logic pi_hit_r, tx_valid_r, tx_last_r, tx_spont_r, user_valid_r;
    logic [3:0] tx_index_r;
    logic [7:0] lat [5];
    int bad_count, checked, exp_cnt, i;

    dpsd_assembler i_dpsd_assembler (.clock(clock), .rst_n(rst_n), .cfg_diag_base(base),
        .pi_wr(pi_wr), .pi_rd(pi_rd), .pi_addr(pi_addr), .pi_wdata(pi_wdata),
        .pi_rdata_r(pi_rdata_r), .pi_hit_r(pi_hit_r), .st_not_ready(st[0]),
        .st_cfg_mismatch(st[1]), .st_unsupported(st[2]), .st_wrong_param(st[3]),
        .st_need_param(st[4]), .st_static_diag(st[5]), .st_resp_mon(st[6]),
        .st_freeze_rx(st[7]), .st_sync_rx(st[8]), .st_overflow(st[9]), .master_addr(ma),
        .ident_num(idn), .err_active(err_active), .err_code(err_code), .diag_req(diag_req),
        .tx_valid_r(tx_valid_r), .tx_ready(tx_ready), .tx_byte_r(tx_byte_r),
        .tx_index_r(tx_index_r), .tx_last_r(tx_last_r), .tx_spont_r(tx_spont_r),
        .user_valid_r(user_valid_r), .msg_code_r(msg_code_r));
    dpsd_master_model i_dpsd_master_model (.clock(clock), .rst_n(rst_n),
        .tx_valid_r(tx_valid_r), .tx_byte_r(tx_byte_r), .tx_index_r(tx_index_r),
        .tx_last_r(tx_last_r), .tx_spont_r(tx_spont_r), .tx_ready(tx_ready), .stall(stall));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        pi_wr = 1'b1;
        pi_addr = a;
        pi_wdata = d;
        @(posedge clock); #1;
        pi_wr = 1'b0;
        @(posedge clock);
        #1;
    endtask

    // read data stands one cycle only, so it is sampled right after the edge
    task automatic rd(input logic [10:0] a, input logic [7:0] e, input logic h);
        pi_rd = 1'b1;
        pi_addr = a;
        @(posedge clock); #1;
        pi_rd = 1'b0;
        chk(pi_rdata_r, e);
        chk(pi_hit_r, h);
        @(posedge clock);
        #1;
    endtask

    function automatic logic [7:0] exp_byte(input int k, input logic [7:0] m);
        case (k)
            0: exp_byte = {1'b0, st[3], 1'b0, st[2], m != 8'h00, st[1], st[0], 1'b0};
            1: exp_byte = {2'b00, st[8:6], 1'b1, st[5:4]};
            2: exp_byte = {st[9], 7'h00};
            3: exp_byte = ma;
            4: exp_byte = idn[15:8];
            5: exp_byte = idn[7:0];
            6: exp_byte = 8'h0a;
            7: exp_byte = m;
            8, 9, 10: exp_byte = 8'h00;
            default: exp_byte = lat[k-11];
        endcase
    endfunction

    task automatic wait_tel(input logic sp, input logic [7:0] m);
        int n;
        n = 0;
        exp_cnt++;
        while (i_dpsd_master_model.tel_cnt != exp_cnt && n < 300) begin
            @(posedge clock); #1;
            n++;
        end
        if (i_dpsd_master_model.tel_cnt != exp_cnt) begin
            bad_count++;
            $display("FAIL %0t telegram missing", $time);
            finish_test;
        end
        for (int k = 0; k < 16; k++) chk(i_dpsd_master_model.tel[k], exp_byte(k, m));
        chk(i_dpsd_master_model.spont, sp);
    endtask

    task automatic req;
        diag_req = 1'b1;
        @(posedge clock); #1;
        diag_req = 1'b0;
        @(posedge clock);
        #1;
    endtask

    initial begin
        rst_n = 1'b0;
        {pi_wr, pi_rd, diag_req, err_active, stall} = 5'h00;
        {base, pi_addr, pi_wdata, err_code} = 0;
        base = 11'h020;
        st = 10'h14b;
        ma = 8'h05;
        idn = 16'h9c3e;
        for (i = 0; i < 5; i++) lat[i] = 8'h00;
        repeat (4) @(posedge clock);
        #1;
        rst_n = 1'b1;
        chk(tx_valid_r, 1'b0);
        chk(user_valid_r, 1'b0);
        rd(base, 8'h00, 1'b1);
        for (i = 1; i < 6; i++) wr(base + 11'(i), 8'ha0 + 8'(i));
        for (i = 1; i < 6; i++) rd(base + 11'(i), 8'ha0 + 8'(i), 1'b1);
        rd(base + 11'h006, 8'h00, 1'b0);
        rd(base - 11'h001, 8'h00, 1'b0);
        stall = 1'b1;
        req();
        wait_tel(1'b0, 8'h00);
        chk(msg_code_r, 8'h00);
        wr(base, 8'h03);
        rd(base, 8'h00, 1'b1);
        repeat (30) @(posedge clock);
        chk(8'(i_dpsd_master_model.tel_cnt), 8'(exp_cnt));
        st = 10'h2b4;
        wr(base, 8'h01);
        for (i = 0; i < 5; i++) lat[i] = 8'ha1 + 8'(i);
        wait_tel(1'b1, 8'h40);
        chk(user_valid_r, 1'b1);
        chk(msg_code_r, 8'h40);
        wr(base + 11'h001, 8'h55);
        req();
        wait_tel(1'b0, 8'h40);
        stall = 1'b0;
        for (i = 8'h12; i <= 8'h17; i++) begin
            err_code = 8'(i);
            err_active = 1'b1;
            wait_tel(1'b1, 8'(i));
            chk(msg_code_r, 8'(i));
        end
        err_active = 1'b0;
        wr(base, 8'h02);
        wait_tel(1'b1, 8'h00);
        chk(user_valid_r, 1'b0);
        chk(msg_code_r, 8'h00);
        finish_test;
    end
endmodule // dp_slave_diagnostic_assembler_tb
`default_nettype wire
